// [hw/scan_port.sv]
/*
 * Boundary-scan test access port of the memory device, with instruction decode,
 * identification and mode-register captures, bypass cell and boundary chain.
 * Assumes the test pins arrive asynchronously and the test clock is far slower
 * than CLK, so every pin is oversampled through three flip-flops.
 */
`timescale 1ns/100ps
// Overview of operation
// - Extest and sample capture ring, select chain.
// - Identification code loads identification word, selects it.
// - Clamp selects bypass, pins driven from chain.
// - High-Z selects bypass, all outputs float.
// - Mode-pair code captures first and second words.
// - Mode-third code captures third mode word.
// - Bypass code selects one-bit bypass cell.
// - Identification word revision, part, maker, one.
// - Mode-pair layout with zero gaps and one.
// - Bit thirteen reports repair capability.
// - Third word at bits ten to one.
// - Boundary chain holds 135 cells fixed order.
// - Identification code loaded at reset states.
// - New instruction acts only at update-IR.
// - Capture in capture-DR, shift LSB-first toward output.
module scan_port
   import scan_port_pkg::*;
#(
   parameter int CHAIN_W = BSR_W
) (
   // System clock, reset, enable.
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   // Test pins from the external controller.
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   output logic TDO,
   output logic TDO_OE_N,
   // Pin ring and mode words.
   input wire logic [CHAIN_W-1:0] RING_IN,
   input wire logic [MODE_W-1:0] MODE_WORD_FIRST,
   input wire logic [MODE_W-1:0] MODE_WORD_SECOND,
   input wire logic [MODE3_W-1:0] MODE_WORD_THIRD,
   input wire logic REPAIR_CAPABLE_FLAG,
   // Pin control toward the memory core.
   output logic [CHAIN_W-1:0] PIN_OVERRIDE,
   output logic PIN_FROM_CHAIN,
   output logic PINS_HIGHZ
);
   import scan_port_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] tck_s;
      logic [SYNC_W-1:0] tms_s;
      logic [SYNC_W-1:0] tdi_s;
      logic tck_q;
      tap_state_t st;
      logic [IR_W-1:0] ir_sh;
      logic [IR_W-1:0] ir;
      logic [ID_W-1:0] id_sh;
      logic byp;
      logic [CHAIN_W-1:0] bsr_sh;
      logic [CHAIN_W-1:0] bsr_upd;
      logic tdo;
      logic tdo_oe_n;
   } state_t;

   state_t s_q, s_d;
   logic tck_now, tms_now, tdi_now, rise, fall;
   logic sel_chain, sel_id, serial_bit;
   logic [ID_W-1:0] id_word, pair_word, third_word;

   // Second and third stages must agree before a test clock level counts.
   assign tck_now = (s_q.tck_s[1] == s_q.tck_s[2]) ? s_q.tck_s[2] : s_q.tck_q;
   assign tms_now = s_q.tms_s[2];
   assign tdi_now = s_q.tdi_s[2];
   assign rise = tck_now & ~s_q.tck_q;
   assign fall = ~tck_now & s_q.tck_q;

   assign sel_chain = (s_q.ir == OP_EXTEST) || (s_q.ir == OP_SAMPLE);
   assign sel_id = (s_q.ir == OP_IDCODE) || (s_q.ir == OP_MODEPAIR) ||
                   (s_q.ir == OP_MODETHIRD);

   always_comb begin
      id_word = '0;
      id_word[ID_REV_LSB +: 4] = ID_REVISION;
      id_word[ID_PART_LSB +: 16] = ID_PART;
      id_word[ID_MAKER_LSB +: 11] = ID_MAKER;
      id_word[PRESENCE_BIT] = 1'b1;
      pair_word = '0;
      pair_word[PAIR_SECOND_LSB +: MODE_W] = MODE_WORD_SECOND;
      pair_word[PAIR_REPAIR_BIT] = REPAIR_CAPABLE_FLAG;
      pair_word[PAIR_FIRST_LSB +: MODE_W] = MODE_WORD_FIRST;
      pair_word[PRESENCE_BIT] = 1'b1;
      third_word = '0;
      third_word[THIRD_LSB +: MODE3_W] = MODE_WORD_THIRD;
      third_word[PRESENCE_BIT] = 1'b1;
   end

   always_comb begin
      if (s_q.st == SHIFT_IR) begin
         serial_bit = s_q.ir_sh[0];
      end else if (sel_chain) begin
         serial_bit = s_q.bsr_sh[0];
      end else if (sel_id) begin
         serial_bit = s_q.id_sh[0];
      end else begin
         serial_bit = s_q.byp;
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.tck_s = {s_q.tck_s[1:0], TCK};
      s_d.tms_s = {s_q.tms_s[1:0], TMS};
      s_d.tdi_s = {s_q.tdi_s[1:0], TDI};
      s_d.tck_q = tck_now;
      if (rise) begin
         case (s_q.st)
            TEST_RESET: s_d.st = tms_now ? TEST_RESET : RUN_IDLE;
            RUN_IDLE: s_d.st = tms_now ? SEL_DR : RUN_IDLE;
            SEL_DR: s_d.st = tms_now ? SEL_IR : CAP_DR;
            CAP_DR: s_d.st = tms_now ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: s_d.st = tms_now ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: s_d.st = tms_now ? UPD_DR : PAUSE_DR;
            PAUSE_DR: s_d.st = tms_now ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: s_d.st = tms_now ? UPD_DR : SHIFT_DR;
            UPD_DR: s_d.st = tms_now ? SEL_DR : RUN_IDLE;
            SEL_IR: s_d.st = tms_now ? TEST_RESET : CAP_IR;
            CAP_IR: s_d.st = tms_now ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: s_d.st = tms_now ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: s_d.st = tms_now ? UPD_IR : PAUSE_IR;
            PAUSE_IR: s_d.st = tms_now ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: s_d.st = tms_now ? UPD_IR : SHIFT_IR;
            UPD_IR: s_d.st = tms_now ? SEL_DR : RUN_IDLE;
            default: s_d.st = TEST_RESET;
         endcase
         case (s_q.st)
            TEST_RESET: s_d.ir = OP_IDCODE;
            CAP_IR: s_d.ir_sh = IR_CAPTURE;
            SHIFT_IR: s_d.ir_sh = {tdi_now, s_q.ir_sh[IR_W-1:1]};
            UPD_IR: s_d.ir = s_q.ir_sh;
            CAP_DR: begin
               s_d.byp = 1'b0;
               if (sel_chain) begin
                  s_d.bsr_sh = RING_IN;
               end
               case (s_q.ir)
                  OP_IDCODE: s_d.id_sh = id_word;
                  OP_MODEPAIR: s_d.id_sh = pair_word;
                  OP_MODETHIRD: s_d.id_sh = third_word;
                  default: s_d.id_sh = s_q.id_sh;
               endcase
            end
            SHIFT_DR: begin
               if (sel_chain) begin
                  s_d.bsr_sh = {tdi_now, s_q.bsr_sh[CHAIN_W-1:1]};
               end else if (sel_id) begin
                  s_d.id_sh = {tdi_now, s_q.id_sh[ID_W-1:1]};
               end else begin
                  s_d.byp = tdi_now;
               end
            end
            UPD_DR: begin
               if (sel_chain) begin
                  s_d.bsr_upd = s_q.bsr_sh;
               end
            end
            default: s_d.ir = s_q.ir;
         endcase
      end
      // Output moves on the falling edge so the controller samples it stable.
      if (fall) begin
         s_d.tdo = serial_bit;
         s_d.tdo_oe_n = !((s_q.st == SHIFT_IR) || (s_q.st == SHIFT_DR));
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s_q <= '0;
         s_q.st <= TEST_RESET;
         s_q.ir <= OP_IDCODE;
         s_q.tdo_oe_n <= 1'b1;
      end else if (CE) begin
         s_q <= s_d;
      end
   end

   assign TDO = s_q.tdo;
   assign TDO_OE_N = s_q.tdo_oe_n;
   assign PIN_OVERRIDE = s_q.bsr_upd;
   // Clamp and extest drive pins from the chain; high-z floats them; memory operation is untouched otherwise.
   assign PIN_FROM_CHAIN = (s_q.ir == OP_CLAMP) || (s_q.ir == OP_EXTEST);
   assign PINS_HIGHZ = (s_q.ir == OP_HIGHZ);

   upd_ir_load_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && rise && s_q.st == UPD_IR) |=> (s_q.ir == $past(s_q.ir_sh)))
      else $error("instruction not loaded at update");
   reset_idcode_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (s_q.st == TEST_RESET && CE && rise) |=> (s_q.ir == OP_IDCODE))
      else $error("idcode not loaded in reset state");
   id_capture_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && rise && s_q.st == CAP_DR && s_q.ir == OP_IDCODE) |=> s_q.id_sh == id_word)
      else $error("id word not captured");
   id_layout_a: assert property (@(posedge CLK) disable iff (!RST_N)
      id_word == {ID_REVISION, ID_PART, ID_MAKER, 1'b1})
      else $error("id word layout wrong");
   pair_capture_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && rise && s_q.st == CAP_DR && s_q.ir == OP_MODEPAIR) |=>
      (s_q.id_sh[PAIR_FIRST_LSB +: MODE_W] == $past(MODE_WORD_FIRST)))
      else $error("mode pair not captured");
   pair_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
      pair_word[31:29] == 3'h0 && pair_word[16:14] == 3'h0 && pair_word[0])
      else $error("mode pair gaps wrong");
   repair_bit_a: assert property (@(posedge CLK) disable iff (!RST_N)
      pair_word[PAIR_REPAIR_BIT] == REPAIR_CAPABLE_FLAG)
      else $error("repair flag misplaced");
   third_capture_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && rise && s_q.st == CAP_DR && s_q.ir == OP_MODETHIRD) |=>
      (s_q.id_sh[THIRD_LSB +: MODE3_W] == $past(MODE_WORD_THIRD)) && s_q.id_sh[0])
      else $error("third mode word not captured");
   chain_shift_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && rise && s_q.st == SHIFT_DR && sel_chain) |=>
      (s_q.bsr_sh[CHAIN_W-1] == $past(tdi_now)))
      else $error("chain shift wrong");
   highz_out_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (s_q.ir == OP_HIGHZ) |-> PINS_HIGHZ && !PIN_FROM_CHAIN)
      else $error("high-z not forced");
   tdo_fall_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && !fall) |=> $stable(s_q.tdo))
      else $error("tdo changed off falling edge");
endmodule // scan_port

// [hw/scan_port_pkg.sv]
/*
 * Constants for the memory test access port: instruction codes, scan lengths,
 * identification and mode-capture field positions, and sampler settings.
 * Assumes a single system clock that oversamples the test clock pins.
 */
package scan_port_pkg;
   localparam int IR_W = 8;
   localparam int ID_W = 32;
   localparam int BSR_W = 135;
   localparam int MODE_W = 12;
   localparam int MODE3_W = 10;
   localparam int SYNC_W = 3;

   localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
   localparam logic [IR_W-1:0] OP_SAMPLE = 8'h05;
   localparam logic [IR_W-1:0] OP_CLAMP = 8'h07;
   localparam logic [IR_W-1:0] OP_HIGHZ = 8'h03;
   localparam logic [IR_W-1:0] OP_IDCODE = 8'h21;
   localparam logic [IR_W-1:0] OP_MODEPAIR = 8'h25;
   localparam logic [IR_W-1:0] OP_MODETHIRD = 8'h29;
   localparam logic [IR_W-1:0] OP_BYPASS = 8'hff;

   // Capture pattern of the instruction register: two low bits are 01.
   localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;

   // Identification word fields (arbitrary neutral values).
   localparam logic [3:0] ID_REVISION = 4'h0;
   localparam logic [15:0] ID_PART = 16'h1234;
   localparam logic [10:0] ID_MAKER = 11'h2aa;

   localparam int ID_REV_LSB = 28;
   localparam int ID_PART_LSB = 12;
   localparam int ID_MAKER_LSB = 1;
   localparam int PAIR_SECOND_LSB = 17;
   localparam int PAIR_REPAIR_BIT = 13;
   localparam int PAIR_FIRST_LSB = 1;
   localparam int THIRD_LSB = 1;
   localparam int PRESENCE_BIT = 0;

   typedef enum logic [3:0] {
      TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
      UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
   } tap_state_t;
endpackage

// [sim/scan_host.sv]
/* Model of the external test controller: it makes the test clock, mode select and serial input.
   Assumes the port samples on rising test clock edges and moves its output on falling ones. */
`timescale 1ns/100ps
module scan_host (
   // System clock used as time base.
   input wire logic clk,
   // Test pins.
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // The test clock stands low between frames, so every edge is one we asked for.
   task automatic tick(input logic m, input logic d, output logic q);
      tms <= m;
      tdi <= d;
      repeat (8) @(posedge clk);
      q = tdo;
      tck <= 1'b1;
      repeat (8) @(posedge clk);
      tck <= 1'b0;
   endtask
   task automatic walk(input logic [3:0] m, input int n);
      logic q;
      for (int i = 0; i < n; i++) tick(m[i], 1'b0, q);
   endtask
   task automatic shift(input int n, input logic [134:0] d, output logic [134:0] q);
      logic b;
      q = '0;
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, d[i], b);
         q[i] = b;
      end
      walk(4'b0001, 2);
   endtask
   task automatic ir(input logic [7:0] c, output logic [134:0] q);
      walk(4'b0011, 4);
      shift(8, {127'h0, c}, q);
   endtask
   task automatic dr(input int n, input logic [134:0] d, output logic [134:0] q);
      walk(4'b0001, 3);
      shift(n, d, q);
   endtask
   task automatic reset_tap();
      walk(4'b1111, 4);
      walk(4'b0001, 2);
   endtask
endmodule // scan_host

// [sim/tb_top.sv]
/* Self-checking bench for the test access port: random mode words and ring levels,
   every implemented code and one reserved code. Assumes the controller model scan_host. */
`timescale 1ns/100ps
module tb_top;
   import scan_port_pkg::*;
   logic clk = 1'b0;
   logic rst_n, tck, tms, tdi, tdo, tdo_oe_n, from_chain, highz, flag;
   logic ce = 1'b1;
   logic [BSR_W-1:0] ring, override, q, d;
   logic [MODE_W-1:0] m1, m2;
   logic [MODE3_W-1:0] m3;
   logic [31:0] seed = 32'd12598;
   logic [7:0] ops [5] = '{OP_EXTEST, OP_CLAMP, OP_HIGHZ, OP_BYPASS, 8'h42};
   int n_mismatch = 0;
   int num_checks = 0;
   int cycles = 0;
   always #2.5 clk = ~clk;
   // With the driver disabled the controller sees the inverse, so a shift with
   // the output enable off reads wrong bits instead of a stale level.
   scan_host HOST (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo ^ tdo_oe_n));
   scan_port DUT (.CLK(clk), .RST_N(rst_n), .CE(ce), .TCK(tck), .TMS(tms), .TDI(tdi),
      .TDO(tdo), .TDO_OE_N(tdo_oe_n), .RING_IN(ring), .MODE_WORD_FIRST(m1),
      .MODE_WORD_SECOND(m2), .MODE_WORD_THIRD(m3), .REPAIR_CAPABLE_FLAG(flag),
      .PIN_OVERRIDE(override), .PIN_FROM_CHAIN(from_chain), .PINS_HIGHZ(highz));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [BSR_W-1:0] id_word();
      return {103'h0, ID_REVISION, ID_PART, ID_MAKER, 1'b1};
   endfunction
   task automatic chk_vec(input logic [BSR_W-1:0] got, input logic [BSR_W-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_vec({134'h0, got}, {134'h0, exp});
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // The ceiling leaves about four times the expected run length.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      rst_n = 1'b0;
      ring = '0;
      {flag, m3, m2, m1} = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      HOST.reset_tap();
      HOST.dr(32, '0, q);
      chk_vec(q, id_word());
      chk_bit(tdo_oe_n, 1'b1);
      for (int r = 0; r < 4; r++) begin
         {flag, m3, m2, m1} <= (r == 0) ? '1 : 35'({xs(), xs()});
         HOST.ir(OP_MODEPAIR, q);
         chk_vec(q, {127'h0, IR_CAPTURE});
         HOST.dr(32, '0, q);
         chk_vec(q, {103'h0, 3'h0, m2, 3'h0, flag, m1, 1'b1});
         HOST.ir(OP_MODETHIRD, q);
         HOST.dr(32, '0, q);
         chk_vec(q, {103'h0, 21'h0, m3, 1'b1});
      end
      ring <= BSR_W'({xs(), xs(), xs(), xs(), xs()});
      d = BSR_W'({xs(), xs(), xs(), xs(), xs()});
      HOST.ir(OP_SAMPLE, q);
      HOST.dr(BSR_W, d, q);
      chk_vec(q, ring);
      chk_vec(override, d);
      for (int i = 0; i < 5; i++) begin
         d = BSR_W'({xs(), xs(), xs(), xs(), xs()});
         HOST.ir(ops[i], q);
         chk_bit(from_chain, ops[i] == OP_EXTEST || ops[i] == OP_CLAMP);
         chk_bit(highz, ops[i] == OP_HIGHZ);
         HOST.dr(ops[i] == OP_EXTEST ? BSR_W : 2, d, q);
         chk_vec(q, ops[i] == OP_EXTEST ? ring : {133'h0, d[0], 1'b0});
      end
      // A reset walk with the enable low must leave the reserved code in place.
      ce <= 1'b0;
      HOST.reset_tap();
      ce <= 1'b1;
      HOST.dr(2, d, q);
      chk_vec(q, {133'h0, d[0], 1'b0});
      HOST.reset_tap();
      HOST.dr(32, '0, q);
      chk_vec(q, id_word());
      HOST.ir(OP_BYPASS, q);
      HOST.ir(OP_IDCODE, q);
      HOST.dr(32, '0, q);
      chk_vec(q, id_word());
      stop_test();
   end
endmodule // tb_top
